/* File: tc8_pkg.sv */
// What this block does
// R1: Counter write blocks matches in next tick.
// R2: Software avoids writing count equal to match.
// R3: Software presets wave output before pin direction.
// R4: Wave output keeps value; reset clears it.
// R5: Action bits act from next match, unbuffered.
// R6: Nonzero action replaces port value with wave.
// R7: Wave visible only when pin direction output.
// R8: Action zero leaves wave output unchanged.
// R9: Force strobe applies action immediately, non-PWM.
// R10: Action bits never change the count sequence.
// R11: Normal mode counts up, wrapping ff to 00.
// R12: Normal overflow flag set as count hits zero.
// R13: Clear-on-match returns count to zero at A.
// R14: Match A unbuffered; lower value wraps first.
// R15: Clear-on-match sets flag A at top.
// R16: Action one toggles output on every match.
// R17: Toggle rate is tick over 2(1+A).
// R18: Clear-on-match overflow set passing max to 00.
// R19: Match flag set one tick later; write-one clears.
// R20: Force sets no flag, keeps counter untouched.
// R21: Counter write beats clear and count.
// R22: Action two clears, three sets output.
package tc8_pkg;

  // ------------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------------
  localparam logic [7:0] CTRL_OFS    = 8'h00;
  localparam logic [7:0] COUNT_OFS   = 8'h04;
  localparam logic [7:0] MATCH_A_OFS = 8'h08;
  localparam logic [7:0] MATCH_B_OFS = 8'h0c;
  localparam logic [7:0] FLAG_OFS    = 8'h10;
  localparam logic [7:0] FORCE_OFS   = 8'h14;
  localparam logic [7:0] PORT_OFS    = 8'h18;

  // ------------------------------------------------------------------
  // Field positions and reset values
  // ------------------------------------------------------------------
  localparam int         FLAG_OVF_BIT = 0;
  localparam int         FLAG_MA_BIT  = 1;
  localparam int         FLAG_MB_BIT  = 2;
  localparam int         FORCE_A_BIT  = 0;
  localparam int         FORCE_B_BIT  = 1;
  localparam int         PORT_PIN_LSB = 8;
  localparam logic [7:0] COUNT_RST    = 8'h00;
  localparam logic [7:0] MATCH_RST    = 8'h00;
  localparam logic [7:0] CTRL_RST     = 8'h00;
  localparam logic [2:0] FLAG_RST     = 3'h0;
  localparam logic [3:0] PORT_RST     = 4'h0;
  localparam logic       WAVE_RST     = 1'b0;

  // ------------------------------------------------------------------
  // Counter limits, mode and action codes
  // ------------------------------------------------------------------
  localparam logic [7:0] COUNT_MAX    = 8'hff;
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;
  localparam logic [2:0] WGM_NORMAL   = 3'h0;
  localparam logic [2:0] WGM_CLEAR    = 3'h2;
  localparam logic [1:0] ACT_NONE     = 2'h0;
  localparam logic [1:0] ACT_TOGGLE   = 2'h1;
  localparam logic [1:0] ACT_CLEAR    = 2'h2;
  localparam logic [1:0] ACT_SET      = 2'h3;

  typedef struct packed {
    logic [1:0] out_action_b;
    logic [1:0] out_action_a;
    logic       rsvd;
    logic [2:0] wave_gen_sel;
  } ctrl_s;

  typedef struct packed {
    logic [1:0] dir;
    logic [1:0] val;
  } port_s;

  function automatic logic non_pwm(input logic [2:0] mode);
    return (mode == WGM_NORMAL) || (mode == WGM_CLEAR);
  endfunction

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    return addr == ofs;
  endfunction

endpackage

/* File: tc8_wave_unit.sv */
module tc8_wave_unit (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       ce,
  input  wire logic [2:0] wave_gen_sel,
  input  wire logic [1:0] out_action,
  input  wire logic       match_ev,
  input  wire logic       force_ev,
  output logic            wave_out
);

  logic wave_reg;
  logic wave_next;
  logic act;

  // ------------------------------------------------------------------
  // Output action
  // ------------------------------------------------------------------
  // The action code is read live, so a new code takes hold at the very next event.
  always_comb begin
    act       = (match_ev | force_ev) & tc8_pkg::non_pwm(wave_gen_sel); // [R5] [R9]
    wave_next = wave_reg;
    if (act) begin
      case (out_action)
        tc8_pkg::ACT_TOGGLE: wave_next = ~wave_reg; // [R16]
        tc8_pkg::ACT_CLEAR:  wave_next = 1'b0; // [R22]
        tc8_pkg::ACT_SET:    wave_next = 1'b1; // [R22]
        default:             wave_next = wave_reg; // [R8]
      endcase
    end
  end

  // A mode change has no path into this register, so the level survives it.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wave_reg <= tc8_pkg::WAVE_RST; // [R4]
    end else if (ce) begin
      wave_reg <= wave_next;
    end
  end

  assign wave_out = wave_reg;

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_idle_hold: assert property ( // [R8]
    (ce && out_action == tc8_pkg::ACT_NONE) |=> wave_reg == $past(wave_reg))
    else $error("wave output moved with action zero");

  chk_toggle_flip: assert property ( // [R16]
    (ce && act && out_action == tc8_pkg::ACT_TOGGLE) |=> wave_reg != $past(wave_reg))
    else $error("toggle action did not flip the wave output");

  chk_force_set: assert property ( // [R9]
    (ce && force_ev && tc8_pkg::non_pwm(wave_gen_sel) && out_action == tc8_pkg::ACT_SET)
    |=> wave_reg)
    else $error("forced set did not raise the wave output");

  chk_mode_keep: assert property ( // [R4]
    (ce && !match_ev && !force_ev && wave_gen_sel != $past(wave_gen_sel))
    |=> wave_reg == $past(wave_reg))
    else $error("wave output changed on a mode change");

endmodule // tc8_wave_unit

/* File: timer8_compare_output_normal_ctc.sv */
module timer8_compare_output_normal_ctc (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        timer_tick,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [1:0]  pin_in,
  output logic      [1:0]  pin_out,
  output logic      [1:0]  pin_oe
);

  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  tc8_pkg::ctrl_s ctrl_reg;
  tc8_pkg::port_s port_reg;
  logic [7:0]     count_reg;
  logic [7:0]     count_next;
  logic [7:0]     match_a_reg;
  logic [7:0]     match_b_reg;
  logic [2:0]     flag_reg;
  logic [2:0]     flag_next;
  logic [2:0]     flag_set;
  logic [2:0]     flag_clr;
  logic           block_reg;
  logic           block_next;
  logic           wr_seen_reg;
  logic [1:0]     pin_meta_reg;
  logic [1:0]     pin_sync_reg;
  logic [1:0]     pin_out_reg;
  logic [1:0]     pin_oe_reg;
  logic [31:0]    prdata_reg;
  logic [31:0]    rd_word;
  logic           mapped;
  logic           wr_en;
  logic           rd_setup;
  logic           cnt_wr;
  logic           tick;
  logic           clr_mode;
  logic           match_a;
  logic           match_b;
  logic           top_clear;
  logic           wrap;
  logic           force_a;
  logic           force_b;
  logic           wave_a;
  logic           wave_b;
  logic [1:0]     wave_pin;

  // ------------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------------
  // While the clock enable is low the slave stalls the bus, so no write is
  // lost in a frozen cycle.
  assign pready   = ce;
  assign wr_en    = psel & penable & pwrite & ce;
  assign rd_setup = psel & ~penable & ~pwrite & ce;
  assign cnt_wr   = wr_en & tc8_pkg::hit(paddr, tc8_pkg::COUNT_OFS);

  always_comb begin
    mapped = tc8_pkg::hit(paddr, tc8_pkg::CTRL_OFS)
           | tc8_pkg::hit(paddr, tc8_pkg::COUNT_OFS)
           | tc8_pkg::hit(paddr, tc8_pkg::MATCH_A_OFS)
           | tc8_pkg::hit(paddr, tc8_pkg::MATCH_B_OFS)
           | tc8_pkg::hit(paddr, tc8_pkg::FLAG_OFS)
           | tc8_pkg::hit(paddr, tc8_pkg::FORCE_OFS)
           | tc8_pkg::hit(paddr, tc8_pkg::PORT_OFS);
  end

  assign pslverr = psel & penable & ~mapped;

  always_comb begin
    rd_word = 32'h0000_0000;
    case (paddr)
      tc8_pkg::CTRL_OFS:    rd_word[7:0] = ctrl_reg;
      tc8_pkg::COUNT_OFS:   rd_word[7:0] = count_reg;
      tc8_pkg::MATCH_A_OFS: rd_word[7:0] = match_a_reg;
      tc8_pkg::MATCH_B_OFS: rd_word[7:0] = match_b_reg;
      tc8_pkg::FLAG_OFS:    rd_word[2:0] = flag_reg;
      tc8_pkg::PORT_OFS: begin
        rd_word[3:0] = port_reg;
        rd_word[tc8_pkg::PORT_PIN_LSB +: 2] = pin_sync_reg;
      end
      default:              rd_word = 32'h0000_0000;
    endcase
  end

  // Read data is captured in the setup phase so that it comes from a flop.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
    end else if (rd_setup) begin
      prdata_reg <= rd_word;
    end
  end

  assign prdata = prdata_reg;

  // ------------------------------------------------------------------
  // Control, compare and port registers
  // ------------------------------------------------------------------
  // Action bits land here directly; nothing holds them back for a period end.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= tc8_pkg::CTRL_RST;
    end else if (wr_en && tc8_pkg::hit(paddr, tc8_pkg::CTRL_OFS)) begin
      ctrl_reg <= pwdata[7:0]; // [R5]
    end
  end

  // Compare values are unbuffered in both supported modes.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_a_reg <= tc8_pkg::MATCH_RST;
      match_b_reg <= tc8_pkg::MATCH_RST;
    end else if (wr_en) begin
      if (tc8_pkg::hit(paddr, tc8_pkg::MATCH_A_OFS)) begin
        match_a_reg <= pwdata[7:0]; // [R14]
      end
      if (tc8_pkg::hit(paddr, tc8_pkg::MATCH_B_OFS)) begin
        match_b_reg <= pwdata[7:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_reg <= tc8_pkg::PORT_RST;
    end else if (wr_en && tc8_pkg::hit(paddr, tc8_pkg::PORT_OFS)) begin
      port_reg <= pwdata[3:0];
    end
  end

  // ------------------------------------------------------------------
  // Counter
  // ------------------------------------------------------------------
  assign tick    = timer_tick & ce;
  assign clr_mode  = ctrl_reg.wave_gen_sel == tc8_pkg::WGM_CLEAR;
  // Only the mode bits steer the sequence; action bits never reach here.
  assign match_a   = tick & ~block_reg & (count_reg == match_a_reg); // [R1] [R10]
  assign match_b   = tick & ~block_reg & (count_reg == match_b_reg); // [R1]
  assign top_clear = match_a & clr_mode; // [R13]
  assign wrap      = tick & ~cnt_wr & (count_reg == tc8_pkg::COUNT_MAX); // [R12] [R18]

  // A match A below the count is passed by, so the count runs on to the
  // top and wraps before it can meet it again.
  always_comb begin
    count_next = count_reg;
    if (cnt_wr) begin
      count_next = pwdata[7:0]; // [R21]
    end else if (top_clear) begin
      count_next = tc8_pkg::COUNT_BOTTOM; // [R13] [R17]
    end else if (tick) begin
      count_next = count_reg + 8'h01; // [R11] [R14]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_reg <= tc8_pkg::COUNT_RST;
    end else if (ce) begin
      count_reg <= count_next;
    end
  end

  // The block stays armed until a tick arrives, however long the timer sits
  // stopped, and that one tick sees no match.
  always_comb begin
    block_next = block_reg;
    if (cnt_wr) begin
      block_next = 1'b1; // [R1]
    end else if (tick) begin
      block_next = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      block_reg <= 1'b0;
    end else if (ce) begin
      block_reg <= block_next;
    end
  end

  // ------------------------------------------------------------------
  // Flags
  // ------------------------------------------------------------------
  // The match flags set at the tick after the equality has stood for a
  // whole tick period; a set in the clearing cycle wins.
  always_comb begin
    flag_set = 3'h0;
    flag_clr = 3'h0;
    flag_set[tc8_pkg::FLAG_OVF_BIT] = wrap; // [R12] [R18]
    flag_set[tc8_pkg::FLAG_MA_BIT]  = match_a; // [R15] [R19]
    flag_set[tc8_pkg::FLAG_MB_BIT]  = match_b; // [R19]
    if (wr_en && tc8_pkg::hit(paddr, tc8_pkg::FLAG_OFS)) begin
      flag_clr = pwdata[2:0]; // [R19]
    end
    flag_next = (flag_reg & ~flag_clr) | flag_set;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_reg <= tc8_pkg::FLAG_RST;
    end else if (ce) begin
      flag_reg <= flag_next;
    end
  end

  // ------------------------------------------------------------------
  // Waveform outputs and pins
  // ------------------------------------------------------------------
  // Force strobes feed only the wave units, never the flags or the counter.
  assign force_a = wr_en & tc8_pkg::hit(paddr, tc8_pkg::FORCE_OFS)
                 & pwdata[tc8_pkg::FORCE_A_BIT]; // [R20]
  assign force_b = wr_en & tc8_pkg::hit(paddr, tc8_pkg::FORCE_OFS)
                 & pwdata[tc8_pkg::FORCE_B_BIT]; // [R20]

  tc8_wave_unit u_wave_a (
    .pclk         (pclk),
    .presetn      (presetn),
    .ce           (ce),
    .wave_gen_sel (ctrl_reg.wave_gen_sel),
    .out_action   (ctrl_reg.out_action_a),
    .match_ev     (match_a),
    .force_ev     (force_a),
    .wave_out     (wave_a)
  );

  tc8_wave_unit u_wave_b (
    .pclk         (pclk),
    .presetn      (presetn),
    .ce           (ce),
    .wave_gen_sel (ctrl_reg.wave_gen_sel),
    .out_action   (ctrl_reg.out_action_b),
    .match_ev     (match_b),
    .force_ev     (force_b),
    .wave_out     (wave_b)
  );

  // The override ignores the mode; the pin enable stays with the direction bit.
  always_comb begin
    wave_pin[0] = (ctrl_reg.out_action_a != tc8_pkg::ACT_NONE) ? wave_a : port_reg.val[0];
    wave_pin[1] = (ctrl_reg.out_action_b != tc8_pkg::ACT_NONE) ? wave_b : port_reg.val[1];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out_reg <= 2'h0;
      pin_oe_reg  <= 2'h0;
    end else if (ce) begin
      pin_out_reg <= wave_pin; // [R6]
      pin_oe_reg  <= port_reg.dir; // [R7]
    end
  end

  assign pin_out = pin_out_reg;
  assign pin_oe  = pin_oe_reg;

  // Pin levels come from outside the clock domain and are synchronised.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_meta_reg <= 2'h0;
      pin_sync_reg <= 2'h0;
    end else if (ce) begin
      pin_meta_reg <= pin_in;
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_seen_reg <= 1'b0;
    end else if (ce && (cnt_wr || tick)) begin
      wr_seen_reg <= cnt_wr;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  chk_write_wins: assert property ( // [R21]
    cnt_wr |=> count_reg == $past(pwdata[7:0]))
    else $error("counter write did not take priority");

  chk_normal_count: assert property ( // [R11]
    (tick && !cnt_wr && ctrl_reg.wave_gen_sel == tc8_pkg::WGM_NORMAL)
    |=> count_reg == $past(count_reg) + 8'h01)
    else $error("normal mode did not count up by one");

  chk_top_clear: assert property ( // [R13]
    (tick && !cnt_wr && !block_reg && clr_mode && count_reg == match_a_reg)
    |=> count_reg == tc8_pkg::COUNT_BOTTOM)
    else $error("counter not cleared at match A");

  chk_overflow_set: assert property ( // [R12]
    (tick && !cnt_wr && count_reg == tc8_pkg::COUNT_MAX)
    |=> count_reg == tc8_pkg::COUNT_BOTTOM && flag_reg[tc8_pkg::FLAG_OVF_BIT])
    else $error("overflow flag not set with the wrap to zero");

  chk_match_blocked: assert property ( // [R1]
    (wr_seen_reg && tick && !cnt_wr && !flag_reg[tc8_pkg::FLAG_MA_BIT])
    |=> !flag_reg[tc8_pkg::FLAG_MA_BIT])
    else $error("match flag set in the tick after a counter write");

  chk_flag_a_set: assert property ( // [R15]
    match_a |=> flag_reg[tc8_pkg::FLAG_MA_BIT] ##1 1'b1)
    else $error("match flag A not set at a match");

  chk_force_quiet: assert property ( // [R20]
    (force_a && !match_a && !flag_reg[tc8_pkg::FLAG_MA_BIT] && !cnt_wr && !tick)
    |=> !flag_reg[tc8_pkg::FLAG_MA_BIT] && $stable(count_reg))
    else $error("force strobe touched the flag or the counter");

  chk_pin_follow: assert property ( // [R6]
    (ce && ctrl_reg.out_action_a != tc8_pkg::ACT_NONE)
    |=> pin_out_reg[0] == $past(wave_a))
    else $error("pin A did not follow the wave output");

  chk_pin_enable: assert property ( // [R7]
    ce |=> pin_oe_reg == $past(port_reg.dir))
    else $error("pin enables did not follow the direction bits");

endmodule // timer8_compare_output_normal_ctc

/* File: timer8_compare_output_normal_ctc_tb.sv */
`define CHECK(g, e) begin num_checks++; if ((g) !== (e)) begin bad_count++; $display("[ERR] %0t ns: got %h expected %h", $time, g, e); end end

module timer8_compare_output_normal_ctc_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ------------------------------------------------------------------
  // Stimulus and observation signals
  // ------------------------------------------------------------------
  logic        pclk;
  logic        presetn;
  logic        ce;
  logic        timer_tick;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [1:0]  pin_in;
  logic [1:0]  pin_out;
  logic [1:0]  pin_oe;
  int          bad_count;
  int          num_checks;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] port;
    logic [1:0] pin;
  } act_row_s;

  // Each row writes control and port, forces both channels, then expects the pins.
  localparam act_row_s ROWS [7] = '{
    '{8'hf0, 8'h00, 2'h3}, '{8'ha0, 8'h0c, 2'h0}, '{8'h50, 8'h0c, 2'h3},
    '{8'h90, 8'h0c, 2'h0}, '{8'h00, 8'h0d, 2'h1}, '{8'h52, 8'h0d, 2'h3},
    '{8'h73, 8'h0c, 2'h3}};

  timer8_compare_output_normal_ctc u_dut (
    .pclk       (pclk),
    .presetn    (presetn),
    .ce         (ce),
    .timer_tick (timer_tick),
    .psel       (psel),
    .penable    (penable),
    .pwrite     (pwrite),
    .paddr      (paddr),
    .pwdata     (pwdata),
    .prdata     (prdata),
    .pready     (pready),
    .pslverr    (pslverr),
    .pin_in     (pin_in),
    .pin_out    (pin_out),
    .pin_oe     (pin_oe)
  );

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  // ------------------------------------------------------------------
  // Bus and timer tasks
  // ------------------------------------------------------------------
  // Every transfer starts one edge after the previous release, so psel never
  // gets two assignments in one time step.
  task automatic apb_xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                          output logic [31:0] q, output logic er);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      bad_count++;
      $display("[ERR] %0t ns: no ready from slave", $time);
    end
    q = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic        er;
    apb_xfer(a, 1'b1, d, q, er);
  endtask

  task automatic chk_rd(input logic [7:0] a, input logic [31:0] e, input logic ee = 1'b0);
    logic [31:0] q;
    logic        er;
    apb_xfer(a, 1'b0, 32'h0, q, er);
    `CHECK(q, e);
    `CHECK(er, ee);
  endtask

  task automatic ticks(input int n);
    @(posedge pclk);
    timer_tick <= 1'b1;
    repeat (n) @(posedge pclk);
    timer_tick <= 1'b0;
  endtask

  // Counts edges between two changes of wave output A.
  task automatic half_period(output int n);
    logic p;
    int   i;
    @(posedge pclk);
    p = pin_out[0];
    for (i = 0; i < 600 && pin_out[0] === p; i++) @(posedge pclk);
    p = pin_out[0];
    n = 0;
    for (i = 0; i < 600 && pin_out[0] === p; i++) begin
      @(posedge pclk);
      n++;
    end
  endtask

  task automatic print_verdict();
    if (bad_count == 0 && num_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    print_verdict();
  end

  // ------------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------------
  initial begin
    logic [31:0] q;
    logic        er;
    int          n;
    bad_count = 0;
    num_checks = 0;
    presetn = 1'b0;
    ce = 1'b1;
    timer_tick = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pin_in = 2'h2;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    `CHECK({pin_oe, pin_out}, 4'h0);
    for (int a = 0; a <= 8'h1c; a += 4) begin
      chk_rd(8'(a), (8'(a) == tc8_pkg::PORT_OFS) ? 32'h200 : 32'h0, a == 8'h1c);
    end
    // Forced actions run with the pin direction still input first.
    for (int r = 0; r < 7; r++) begin
      wr(tc8_pkg::CTRL_OFS, {24'h0, ROWS[r].ctrl});
      wr(tc8_pkg::PORT_OFS, {24'h0, ROWS[r].port});
      wr(tc8_pkg::FORCE_OFS, 32'h3);
      @(posedge pclk);
      @(posedge pclk);
      #1;
      `CHECK({pin_oe, pin_out}, {ROWS[r].port[3:2], ROWS[r].pin});
    end
    chk_rd(tc8_pkg::COUNT_OFS, 32'h0);
    chk_rd(tc8_pkg::FLAG_OFS, 32'h0);
    // Normal mode: wrap, overflow, match flag timing and write blocking.
    wr(tc8_pkg::CTRL_OFS, 32'h0);
    wr(tc8_pkg::MATCH_A_OFS, 32'h10);
    wr(tc8_pkg::MATCH_B_OFS, 32'h20);
    wr(tc8_pkg::COUNT_OFS, 32'hfd);
    ticks(2);
    chk_rd(tc8_pkg::COUNT_OFS, 32'hff);
    chk_rd(tc8_pkg::FLAG_OFS, 32'h0);
    ticks(1);
    chk_rd(tc8_pkg::COUNT_OFS, 32'h0);
    chk_rd(tc8_pkg::FLAG_OFS, 32'h1);
    wr(tc8_pkg::FLAG_OFS, 32'h1);
    chk_rd(tc8_pkg::FLAG_OFS, 32'h0);
    wr(tc8_pkg::COUNT_OFS, 32'h10);
    ticks(1);
    chk_rd(tc8_pkg::FLAG_OFS, 32'h0);
    chk_rd(tc8_pkg::COUNT_OFS, 32'h11);
    wr(tc8_pkg::COUNT_OFS, 32'h0f);
    ticks(1);
    chk_rd(tc8_pkg::FLAG_OFS, 32'h0);
    ticks(1);
    chk_rd(tc8_pkg::FLAG_OFS, 32'h2);
    timer_tick <= 1'b1;
    wr(tc8_pkg::COUNT_OFS, 32'h40);
    timer_tick <= 1'b0;
    chk_rd(tc8_pkg::COUNT_OFS, 32'h40);
    // Clear-on-match with the top written below the count.
    wr(tc8_pkg::CTRL_OFS, 32'h02);
    wr(tc8_pkg::MATCH_A_OFS, 32'h05);
    wr(tc8_pkg::COUNT_OFS, 32'h10);
    wr(tc8_pkg::FLAG_OFS, 32'h7);
    ticks(8'hef);
    chk_rd(tc8_pkg::COUNT_OFS, 32'hff);
    chk_rd(tc8_pkg::FLAG_OFS, 32'h4);
    ticks(1);
    chk_rd(tc8_pkg::FLAG_OFS, 32'h5);
    ticks(5);
    chk_rd(tc8_pkg::COUNT_OFS, 32'h05);
    ticks(1);
    chk_rd(tc8_pkg::COUNT_OFS, 32'h0);
    chk_rd(tc8_pkg::FLAG_OFS, 32'h7);
    // Toggle output with the tick held high: half period is top plus one.
    wr(tc8_pkg::FLAG_OFS, 32'h7);
    wr(tc8_pkg::CTRL_OFS, 32'h12);
    wr(tc8_pkg::PORT_OFS, 32'h04);
    wr(tc8_pkg::COUNT_OFS, 32'h01);
    timer_tick <= 1'b1;
    for (int m = 7; m >= 0; m = (m == 7) ? 2 : m - 2) begin
      wr(tc8_pkg::MATCH_A_OFS, 32'(m));
      half_period(n);
      `CHECK(n, m + 1);
    end
    timer_tick <= 1'b0;
    apb_xfer(tc8_pkg::FLAG_OFS, 1'b0, 32'h0, q, er);
    `CHECK(q[1], 1'b1);
    // Frozen cycles stall the bus and the counter; the write block outlives them.
    wr(tc8_pkg::MATCH_A_OFS, 32'h20);
    wr(tc8_pkg::COUNT_OFS, 32'h20);
    wr(tc8_pkg::FLAG_OFS, 32'h7);
    ce <= 1'b0;
    timer_tick <= 1'b1;
    repeat (4) @(posedge pclk);
    `CHECK(pready, 1'b0);
    ce <= 1'b1;
    @(posedge pclk);
    timer_tick <= 1'b0;
    chk_rd(tc8_pkg::COUNT_OFS, 32'h21);
    chk_rd(tc8_pkg::FLAG_OFS, 32'h0);
    // Second reset in mid-run clears a wave output that was set.
    wr(tc8_pkg::CTRL_OFS, 32'h30);
    wr(tc8_pkg::FORCE_OFS, 32'h1);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    #1;
    `CHECK({pin_oe, pin_out}, 4'h0);
    @(posedge pclk);
    presetn <= 1'b1;
    wr(tc8_pkg::CTRL_OFS, 32'h10);
    wr(tc8_pkg::PORT_OFS, 32'h04);
    wr(tc8_pkg::FORCE_OFS, 32'h1);
    @(posedge pclk);
    @(posedge pclk);
    #1;
    `CHECK(pin_out[0], 1'b1);
    print_verdict();
  end
endmodule // timer8_compare_output_normal_ctc_tb
